// *** logic/wdt_pkg.sv ***
// Notes on behaviour
// - In watchdog mode, action bit 0 requests NMI, 1 requests internal reset.
// - Run bit 0 holds counter at zero; run bit 1 lets it count.
// - Interval mode raises the interval interrupt on every counter overflow.
// - Watchdog mode raises reset or NMI request on overflow.
// - Wrap flag sets when the counter goes from all ones to zero.
// - Writing 0 to the run bit clears the wrap flag.
// - Writing 0 to the flag after reading it as 1 clears it.
// - An internal reset from the watchdog clears the wrap flag.
package wdt_pkg;
  // ****************
  // Register map
  // ****************
  localparam logic [15:0] CTRL_INDEX = 16'hffbc;
  localparam logic [15:0] COUNT_INDEX = 16'hffbd;
  localparam logic [17:0] CTRL_ADDR = {CTRL_INDEX, 2'b00};
  localparam logic [17:0] COUNT_ADDR = {COUNT_INDEX, 2'b00};
  localparam logic [17:0] IRQ_STATUS_ADDR = 18'h3ff00;
  localparam logic [17:0] IRQ_MASK_ADDR = 18'h3ff04;
  // ****************
  // Control fields
  // ****************
  localparam int WRAP_BIT = 7;
  localparam int MODE_BIT = 6;
  localparam int RUN_BIT = 5;
  localparam int ACTION_BIT = 3;
  localparam int CKS_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  // ****************
  // Interrupt status bits
  // ****************
  localparam int IRQ_INTERVAL = 0;
  localparam int IRQ_NMI = 1;
  localparam int IRQ_RESET = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET_VAL = 3'h0;
  localparam logic [15:0] PRESCALE_RESET = 16'h0000;
endpackage : wdt_pkg

// *** logic/watchdog_interval_timer.sv ***
`timescale 1ns/10ps
module watchdog_interval_timer (
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write
  input wire logic [3:0] sel_i, // Wishbone byte select
  input wire logic [19:0] adr_i, // Wishbone byte address
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  output logic interval_overflow_irq, // Interval interrupt request
  output logic nmi_request, // Non-maskable interrupt request
  output logic reset_request, // Internal reset request
  output logic irq // OR of status bits enabled in the mask register
);
  import wdt_pkg::*;

  // ****************
  // Bus decode
  // ****************
  logic req;
  logic wr;
  logic rd;
  logic hit_ctrl;
  logic hit_count;
  logic hit_stat;
  logic hit_mask;
  logic [7:0] ctrl_reg;
  logic [7:0] count_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic wrap_seen_reg;
  logic [15:0] prescale_reg;
  logic tick;
  logic wrap;
  logic run;
  logic wd_mode;
  logic [2:0] cks;

  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i && sel_i[0];
  assign rd = req && !we_i;
  assign hit_ctrl = adr_i[17:0] == CTRL_ADDR;
  assign hit_count = adr_i[17:0] == COUNT_ADDR;
  assign hit_stat = adr_i[17:0] == IRQ_STATUS_ADDR;
  assign hit_mask = adr_i[17:0] == IRQ_MASK_ADDR;
  assign run = ctrl_reg[RUN_BIT];
  assign wd_mode = ctrl_reg[MODE_BIT];
  assign cks = ctrl_reg[CKS_LSB+2:CKS_LSB];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dat_o <= 32'h0000_0000;
    end else if (rd) begin
      if (hit_ctrl) begin
        dat_o <= {24'h000000, ctrl_reg};
      end else if (hit_count) begin
        dat_o <= {24'h000000, count_reg};
      end else if (hit_stat) begin
        dat_o <= {29'h0, irq_status_reg};
      end else if (hit_mask) begin
        dat_o <= {29'h0, irq_mask_reg};
      end else begin
        dat_o <= 32'h0000_0000;
      end
    end
  end

  // ****************
  // Prescaler
  // ****************
  always_ff @(posedge clock) begin
    if (!rst_n || !run) begin
      prescale_reg <= PRESCALE_RESET;
    end else begin
      prescale_reg <= prescale_reg + 16'h0001;
    end
  end

  // Tick on each carry out of the selected stage
  always_comb begin
    unique case (cks)
      3'h0: tick = &prescale_reg[0:0];
      3'h1: tick = &prescale_reg[1:0];
      3'h2: tick = &prescale_reg[3:0];
      3'h3: tick = &prescale_reg[5:0];
      3'h4: tick = &prescale_reg[7:0];
      3'h5: tick = &prescale_reg[9:0];
      3'h6: tick = &prescale_reg[11:0];
      3'h7: tick = &prescale_reg[13:0];
    endcase
  end

  // ****************
  // Counter
  // ****************
  assign wrap = run && tick && count_reg == COUNT_MAX;

  always_ff @(posedge clock) begin
    if (!rst_n || reset_request) begin
      count_reg <= COUNT_RESET;
    end else if (!run) begin
      count_reg <= COUNT_ZERO;
    end else if (wr && hit_count) begin
      count_reg <= dat_i[7:0];
    end else if (tick) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // ****************
  // Control register
  // ****************
  always_ff @(posedge clock) begin
    if (!rst_n || reset_request) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_reg[MODE_BIT] <= dat_i[MODE_BIT];
        ctrl_reg[RUN_BIT] <= dat_i[RUN_BIT];
        ctrl_reg[ACTION_BIT] <= dat_i[ACTION_BIT];
        ctrl_reg[CKS_LSB+2:CKS_LSB] <= dat_i[CKS_LSB+2:CKS_LSB];
      end
      if (wrap) begin
        ctrl_reg[WRAP_BIT] <= 1'b1;
      end else if (wr && hit_ctrl && !dat_i[RUN_BIT]) begin
        ctrl_reg[WRAP_BIT] <= 1'b0;
      end else if (wr && hit_ctrl && !dat_i[WRAP_BIT] && wrap_seen_reg) begin
        ctrl_reg[WRAP_BIT] <= 1'b0;
      end
    end
  end

  // Flag armed for clearing only after being read as one
  always_ff @(posedge clock) begin
    if (!rst_n || reset_request) begin
      wrap_seen_reg <= 1'b0;
    end else if (rd && hit_ctrl) begin
      wrap_seen_reg <= ctrl_reg[WRAP_BIT];
    end else if (!ctrl_reg[WRAP_BIT]) begin
      wrap_seen_reg <= 1'b0;
    end
  end

  // ****************
  // Overflow requests
  // ****************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      interval_overflow_irq <= 1'b0;
      nmi_request <= 1'b0;
      reset_request <= 1'b0;
    end else begin
      interval_overflow_irq <= wrap && !wd_mode;
      nmi_request <= wrap && wd_mode && !ctrl_reg[ACTION_BIT];
      reset_request <= wrap && wd_mode && ctrl_reg[ACTION_BIT];
    end
  end

  // ****************
  // Interrupt status and mask
  // ****************
  logic [IRQ_W-1:0] events;
  assign events = {reset_request, nmi_request, interval_overflow_irq};

  generate
    for (genvar i = 0; i < IRQ_W; i++) begin : g_stat
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          irq_status_reg[i] <= IRQ_RESET_VAL[i];
        end else if (events[i]) begin
          irq_status_reg[i] <= 1'b1;
        end else if (wr && hit_stat && dat_i[i]) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_mask_reg <= IRQ_RESET_VAL;
    end else if (wr && hit_mask) begin
      irq_mask_reg <= dat_i[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // ****************
  // Checks
  // ****************
  AST_RUN_HOLDS_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    !run |=> count_reg == COUNT_ZERO) else $error("counter not held");
  AST_WRAP_SETS: assert property (@(posedge clock) disable iff (!rst_n)
    wrap && !wd_mode |=> ctrl_reg[WRAP_BIT]) else $error("flag not set");
  AST_INTERVAL: assert property (@(posedge clock) disable iff (!rst_n)
    wrap && !wd_mode |=> interval_overflow_irq && !nmi_request)
    else $error("interval irq missing");
  AST_NMI: assert property (@(posedge clock) disable iff (!rst_n)
    wrap && wd_mode && !ctrl_reg[ACTION_BIT] |=> nmi_request && !reset_request)
    else $error("nmi missing");
  AST_RESET: assert property (@(posedge clock) disable iff (!rst_n)
    wrap && wd_mode && ctrl_reg[ACTION_BIT] |=> reset_request)
    else $error("reset request missing");
  AST_RESET_CLEARS: assert property (@(posedge clock) disable iff (!rst_n)
    reset_request |=> !ctrl_reg[WRAP_BIT]) else $error("flag kept");
  AST_RUN_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
    wr && hit_ctrl && !dat_i[RUN_BIT] && !wrap && !reset_request
    |=> !ctrl_reg[WRAP_BIT]) else $error("run write kept flag");
  AST_UNREAD_NO_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl_reg[WRAP_BIT] && !wrap_seen_reg && wr && hit_ctrl
    && dat_i[RUN_BIT] && !reset_request |=> ctrl_reg[WRAP_BIT])
    else $error("flag cleared unread");
  AST_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    run && wr && hit_count && !reset_request |=> count_reg == $past(dat_i[7:0]))
    else $error("counter load lost");

  // ****************
  // Bus handshake, read data and mask write checks
  // ****************
  AST_ACK_ONE_CYCLE: assert property (@(posedge clock) disable iff (!rst_n)
    ack_o |=> !ack_o)
    else $error("ack held too long");
  AST_ACK_ANSWERS: assert property (@(posedge clock) disable iff (!rst_n)
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  AST_ACK_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
    !(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  AST_READ_HOLDS: assert property (@(posedge clock) disable iff (!rst_n)
    !rd |=> $stable(dat_o))
    else $error("read data moved");
  AST_MASK_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    wr && hit_mask |=> irq_mask_reg == $past(dat_i[IRQ_W-1:0]))
    else $error("mask write lost");

  // ****************
  // Counter checks
  // ****************
  AST_PRESCALE_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
    !run |=> prescale_reg == PRESCALE_RESET)
    else $error("prescaler ran while stopped");
  AST_COUNT_STEP: assert property (@(posedge clock) disable iff (!rst_n)
    run && tick && !(wr && hit_count) && !reset_request
    |=> count_reg == $past(count_reg) + 8'h01) else $error("no step");
  AST_COUNT_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    run && !tick && !(wr && hit_count) && !reset_request
    |=> $stable(count_reg)) else $error("count moved off tick");
  AST_WD_RESET_COUNT: assert property (@(posedge clock) disable iff (!rst_n)
    reset_request |=> count_reg == COUNT_RESET && !run)
    else $error("reset left counter running");

  // ****************
  // Flag checks
  // ****************
  AST_FLAG_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
    !wrap && !(wr && hit_ctrl) && !reset_request
    |=> ctrl_reg[WRAP_BIT] == $past(ctrl_reg[WRAP_BIT]))
    else $error("flag changed alone");
  AST_ONE_WRITE_NOP: assert property (@(posedge clock) disable iff (!rst_n)
    wr && hit_ctrl && dat_i[WRAP_BIT] && dat_i[RUN_BIT] && !wrap
    && !reset_request |=> ctrl_reg[WRAP_BIT] == $past(ctrl_reg[WRAP_BIT]))
    else $error("one write moved flag");
  AST_SEEN_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
    wr && hit_ctrl && !dat_i[WRAP_BIT] && wrap_seen_reg && !wrap
    && !reset_request |=> !ctrl_reg[WRAP_BIT])
    else $error("armed clear ignored");

  // ****************
  // Request checks
  // ****************
  AST_IVL_ALONE: assert property (@(posedge clock) disable iff (!rst_n)
    interval_overflow_irq |-> !nmi_request && !reset_request)
    else $error("interval with watchdog request");
  AST_NMI_ALONE: assert property (@(posedge clock) disable iff (!rst_n)
    nmi_request |-> !reset_request)
    else $error("nmi with reset request");
  AST_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
    !wrap |=> !interval_overflow_irq && !nmi_request && !reset_request)
    else $error("request without wrap");
  AST_RESET_ONLY: assert property (@(posedge clock) disable iff (!rst_n)
    wrap && wd_mode && ctrl_reg[ACTION_BIT]
    |=> !nmi_request && !interval_overflow_irq)
    else $error("wrong request on reset wrap");

  // ****************
  // Status checks
  // ****************
  AST_STAT_IVL: assert property (@(posedge clock) disable iff (!rst_n)
    interval_overflow_irq |=> irq_status_reg[IRQ_INTERVAL])
    else $error("interval status not set");
  AST_STAT_NMI: assert property (@(posedge clock) disable iff (!rst_n)
    nmi_request |=> irq_status_reg[IRQ_NMI])
    else $error("nmi status not set");
  AST_STAT_RESET: assert property (@(posedge clock) disable iff (!rst_n)
    reset_request |=> irq_status_reg[IRQ_RESET])
    else $error("reset status not set");
  AST_STAT_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
    wr && hit_stat && dat_i[IRQ_INTERVAL] && !interval_overflow_irq
    |=> !irq_status_reg[IRQ_INTERVAL]) else $error("status not cleared");
  AST_IRQ_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
    ~|irq_mask_reg |-> !irq)
    else $error("irq while all masked");
endmodule : watchdog_interval_timer

// *** verif/cpu_side_model.sv ***
`timescale 1ns/10ps
module cpu_side_model (
  input wire logic clock, // System clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic interval_overflow_irq, // Interval request
  input wire logic nmi_request, // NMI request
  input wire logic reset_request, // Reset request
  output logic [7:0] cnt_int, // Interval requests taken
  output logic [7:0] cnt_nmi, // NMI requests taken
  output logic [7:0] cnt_rst // Reset requests taken
);
  // Each one-cycle request counted once
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_int <= 8'h00;
      cnt_nmi <= 8'h00;
      cnt_rst <= 8'h00;
    end else begin
      cnt_int <= cnt_int + {7'h00, interval_overflow_irq};
      cnt_nmi <= cnt_nmi + {7'h00, nmi_request};
      cnt_rst <= cnt_rst + {7'h00, reset_request};
    end
  end
endmodule : cpu_side_model

// *** verif/watchdog_interval_timer_bench.sv ***
`timescale 1ns/10ps
module watchdog_interval_timer_bench;
  import wdt_pkg::*;
  logic clock, rst_n, cyc, stb, we, ack_o, ivl, nmi, rsq, irq;
  logic [3:0] sel;
  logic [19:0] adr;
  logic [31:0] wdat, dat_o;
  logic [7:0] ci, cn, cr, q;
  int fail_count = 0;
  int checks = 0;
  watchdog_interval_timer i_dut (.clock(clock), .rst_n(rst_n), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .sel_i(sel), .adr_i(adr), .dat_i(wdat),
    .dat_o(dat_o), .ack_o(ack_o), .interval_overflow_irq(ivl),
    .nmi_request(nmi), .reset_request(rsq), .irq(irq));
  cpu_side_model i_cpu (.clock(clock), .rst_n(rst_n),
    .interval_overflow_irq(ivl), .nmi_request(nmi), .reset_request(rsq),
    .cnt_int(ci), .cnt_nmi(cn), .cnt_rst(cr));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task end_sim;
    $display("Mismatches %0d, checks %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Classic Wishbone single cycle, waits for ack
  task bus(input logic w, input logic [17:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'h0, a};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack_o !== 1'b1) begin
      fail_count++;
      end_sim();
    end
  endtask : bus
  task wait_for(input logic [7:0] ei, input logic [7:0] en, input logic [7:0] er);
    int n;
    for (n = 0; n < 600 && {ci, cn, cr} !== {ei, en, er}; n++) @(posedge clock);
    if ({ci, cn, cr} !== {ei, en, er}) begin
      fail_count++;
      end_sim();
    end
  endtask : wait_for
  task t_defaults;
    bus(1'b0, CTRL_ADDR, 8'h00);
    chk(q, 8'h00);
    bus(1'b0, COUNT_ADDR, 8'h00);
    chk(q, 8'h00);
    bus(1'b0, 18'h00010, 8'h00);
    chk(q, 8'h00);
  endtask : t_defaults
  task t_interval;
    bus(1'b1, CTRL_ADDR, 8'h20);
    bus(1'b1, COUNT_ADDR, 8'hfd);
    wait_for(8'h01, 8'h00, 8'h00);
    bus(1'b0, CTRL_ADDR, 8'h00);
    chk(q, 8'ha0);
    bus(1'b1, CTRL_ADDR, 8'ha0);
    bus(1'b0, CTRL_ADDR, 8'h00);
    chk(q, 8'ha0);
    bus(1'b1, CTRL_ADDR, 8'h20);
    bus(1'b0, CTRL_ADDR, 8'h00);
    chk(q, 8'h20);
    bus(1'b0, IRQ_STATUS_ADDR, 8'h00);
    chk(q, 8'h01);
    chk({7'h00, irq}, 8'h00);
    bus(1'b1, IRQ_MASK_ADDR, 8'h01);
    chk({7'h00, irq}, 8'h01);
    bus(1'b1, IRQ_STATUS_ADDR, 8'h01);
    chk({7'h00, irq}, 8'h00);
  endtask : t_interval
  task t_stop;
    bus(1'b1, COUNT_ADDR, 8'hfe);
    wait_for(8'h02, 8'h00, 8'h00);
    bus(1'b1, CTRL_ADDR, 8'h00);
    bus(1'b0, CTRL_ADDR, 8'h00);
    chk(q, 8'h00);
    bus(1'b1, COUNT_ADDR, 8'h55);
    bus(1'b0, COUNT_ADDR, 8'h00);
    chk(q, 8'h00);
  endtask : t_stop
  task t_watchdog;
    bus(1'b1, CTRL_ADDR, 8'h61);
    bus(1'b1, COUNT_ADDR, 8'hfe);
    wait_for(8'h02, 8'h01, 8'h00);
    bus(1'b0, CTRL_ADDR, 8'h00);
    chk(q, 8'he1);
    bus(1'b1, CTRL_ADDR, 8'h68);
    bus(1'b1, COUNT_ADDR, 8'hfe);
    wait_for(8'h02, 8'h01, 8'h01);
    bus(1'b0, CTRL_ADDR, 8'h00);
    chk(q, 8'h00);
    bus(1'b0, IRQ_STATUS_ADDR, 8'h00);
    chk(q, 8'h07);
  endtask : t_watchdog
  initial begin
    rst_n = 1'b0;
    {cyc, stb, we} = 3'h0;
    sel = 4'h1;
    adr = 20'h00000;
    wdat = 32'h00000000;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_defaults();
    t_interval();
    t_stop();
    t_watchdog();
    end_sim();
  end
endmodule : watchdog_interval_timer_bench
